// [verilog/adcsq_pkg.sv]
package adcsq_pkg;
	// ----------------------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------------------
	localparam logic [7:0]  ADDR_CONV_CTRL      = 8'h23;   // Conversion control
	localparam logic [7:0]  ADDR_CONV_CTRL_FAST = 8'h2E;   // Alias of conversion control, same register
	localparam logic [15:0] CONV_CTRL_RESET     = 16'h0000; // Reset value
	localparam logic [15:0] CONV_CTRL_WMASK     = 16'h07FF; // Writable bits, rest read zero
	// Field positions
	localparam int REJ_BIT     = 10;  // Diagnostic mains rejection enable
	localparam int SEQ_MSB     = 9;   // Sequence mode field high bit
	localparam int SEQ_LSB     = 8;   // Sequence mode field low bit
	localparam int DIAG_LSB    = 4;   // Diagnostic enables start
	localparam int CHAN_LSB    = 0;   // Channel enables start
	localparam int NUM_INPUTS  = 8;   // Four channels then four diagnostics
	// Sequence mode codes
	localparam logic [1:0] SEQ_IDLE   = 2'h0; // Stop, stay powered or power up
	localparam logic [1:0] SEQ_SINGLE = 2'h1; // One pass
	localparam logic [1:0] SEQ_CONT   = 2'h2; // Repeating passes
	localparam logic [1:0] SEQ_PDOWN  = 2'h3; // Stop and power down
	// ----------------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------------
	localparam int CLK_MHZ        = 50;                       // ref_clk rate
	localparam int PWRUP_US       = 100;                      // Converter power-up time
	localparam int PWRUP_CYCLES   = PWRUP_US * CLK_MHZ;       // Least time, exact
	localparam int FAST_SPS       = 4800;                     // Diagnostics, no rejection
	localparam int SLOW_SPS       = 20;                       // Diagnostics, rejection on
	localparam int FAST_CYCLES    = (CLK_MHZ * 1000000) / FAST_SPS;
	localparam int SLOW_CYCLES    = (CLK_MHZ * 1000000) / SLOW_SPS;
	localparam int CONV_CYCLES    = 64;                       // Channel conversion time
	// Sequencer states
	typedef enum logic [3:0] {
		ST_OFF   = 4'b0001, // Powered down
		ST_PWRUP = 4'b0010, // Powering up
		ST_IDLE  = 4'b0100, // Powered, no pass
		ST_CONV  = 4'b1000  // Converting one input
	} adcsq_state_t;
endpackage : adcsq_pkg

// [verilog/adcsq_top.sv]
`timescale 1ns/1ps
// How it works
// - Either control register starts and stops
// - Bit 10 picks diagnostic rate 4.8k/20
// - Bits 9:8 choose sequence mode
// - Code 00 stops, powers up if down
// - Busy held high during power-up
// - Code 01 converts each enabled input once
// - Mode field never self-clears after pass
// - Code 01 from power-down powers up
// - Code 10 repeats passes until stopped
// - Code 11 stops and powers down
// - Bits 7:4 enable diagnostics 3..0
// - Bits 3:0 enable channels D..A
module adcsq_top #(
	parameter int PWRUP_COUNT = adcsq_pkg::PWRUP_CYCLES, // Power-up wait in cycles
	parameter int SLOW_COUNT  = adcsq_pkg::SLOW_CYCLES,  // Diag time, rejection on
	parameter int FAST_COUNT  = adcsq_pkg::FAST_CYCLES,  // Diag time, rejection off
	parameter int CONV_COUNT  = adcsq_pkg::CONV_CYCLES   // Channel conversion time
) (
	input  wire logic        ref_clk,     // System clock
	input  wire logic        rst,         // Async reset, active high
	input  wire logic [7:0]  reg_addr,    // Register address
	input  wire logic        reg_wr,      // Write strobe
	input  wire logic        reg_rd,      // Read strobe
	input  wire logic [15:0] reg_wdata,   // Write data
	output logic      [15:0] reg_rdata,   // Read data, registered
	output logic             adc_busy,    // Registered busy status
	output logic             adc_powered, // Converter power enable
	output logic             conv_start,  // Pulse: start a conversion
	output logic      [2:0]  conv_input,  // Input under conversion
	output logic             conv_done    // Pulse: conversion finished
);
	import adcsq_pkg::*;

	localparam int CW = 32; // Counter width

	// ------------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------------
	// Refuse counts that the down counters cannot serve: a zero count
	// would end a wait before it began and hide a mistyped parameter.
	if (PWRUP_COUNT < 1 || SLOW_COUNT < 1 ||
		FAST_COUNT < 1 || CONV_COUNT < 1) begin : g_bad_count
		$error("adcsq_top: counts must be at least one");
	end

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	logic [15:0]  ctrl_q;     // Conversion control register
	logic         ctrl_wr;    // Write to either control address
	adcsq_state_t state_q;    // Sequencer state
	logic [CW-1:0] cnt_q;     // Shared wait counter
	logic [2:0]   idx_q;      // Current input index
	logic         pass_q;     // A pass is running
	logic [7:0]   enables;    // Channel and diagnostic enables

	// Both addresses write the same converter control
	assign ctrl_wr = reg_wr && (reg_addr == ADDR_CONV_CTRL ||
		reg_addr == ADDR_CONV_CTRL_FAST);
	assign enables = ctrl_q[7:0];

	// Control register keeps written value, no self clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CONV_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_q <= reg_wdata & CONV_CTRL_WMASK;
		end
	end

	// Read port: control register, zero elsewhere
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == ADDR_CONV_CTRL || reg_addr == ADDR_CONV_CTRL_FAST) begin
				reg_rdata <= ctrl_q;
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Next enabled input search
	// ------------------------------------------------------------------------
	// First enabled input at or above a start index, fixed order
	function automatic logic [3:0] find_next(input logic [7:0] en, input logic [3:0] from);
		logic [3:0] res;
		res = 4'h8;
		for (int i = 7; i >= 0; i--) begin
			if (en[i] && i >= int'(from)) begin
				res = 4'(i);
			end
		end
		return res;
	endfunction : find_next

	logic [3:0] first_in; // First enabled input of a pass
	logic [3:0] next_in;  // Next enabled input after current
	assign first_in = find_next(enables, 4'h0);
	assign next_in  = find_next(enables, {1'b0, idx_q} + 4'h1);

	// Conversion time for an input
	function automatic logic [CW-1:0] conv_len(input logic [2:0] idx, input logic rej);
		if (idx >= 3'(DIAG_LSB)) begin
			return rej ? CW'(SLOW_COUNT) : CW'(FAST_COUNT);
		end
		return CW'(CONV_COUNT);
	endfunction : conv_len

	logic [1:0] wmode; // Mode being written
	assign wmode = reg_wdata[SEQ_MSB:SEQ_LSB];

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	// Power, pass and conversion walk
	// Writes take priority over the walk, so that a stop or a power-down
	// lands in the cycle of the write even in the middle of a conversion.
	// A start write is only honoured from off or from idle; a start that
	// arrives while busy is dropped, which is why the host polls busy.
	// The walk itself counts down the shared counter and then either
	// moves to the next enabled input or closes the pass.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q    <= ST_IDLE;
			cnt_q      <= '0;
			idx_q      <= 3'h0;
			pass_q     <= 1'b0;
			conv_start <= 1'b0;
			conv_done  <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			conv_done  <= 1'b0;
			if (ctrl_wr && wmode == SEQ_PDOWN) begin
				state_q <= ST_OFF;
				pass_q  <= 1'b0;
			end else if (ctrl_wr && wmode == SEQ_IDLE) begin
				pass_q <= 1'b0;
				if (state_q == ST_OFF) begin
					state_q <= ST_PWRUP;
					cnt_q   <= CW'(PWRUP_COUNT);
				end else if (state_q == ST_CONV) begin
					state_q <= ST_IDLE;
				end
			end else if (ctrl_wr && (wmode == SEQ_SINGLE || wmode == SEQ_CONT)) begin
				if (state_q == ST_OFF) begin
					state_q <= ST_PWRUP;
					cnt_q   <= CW'(PWRUP_COUNT);
					pass_q  <= 1'b1;
				end else if (state_q == ST_IDLE) begin
					pass_q  <= 1'b1;
				end
			end else begin
				case (state_q)
					ST_OFF: begin
					end
					ST_PWRUP: begin
						// Wait out the converter's power-up time
						if (cnt_q <= CW'(1)) begin
							state_q <= ST_IDLE;
						end else begin
							cnt_q <= cnt_q - CW'(1);
						end
					end
					ST_IDLE: begin
						// Open a pass at the lowest enabled input
						if (pass_q) begin
							if (first_in[3]) begin
								pass_q <= 1'b0; // Nothing enabled
							end else begin
								state_q    <= ST_CONV;
								idx_q      <= first_in[2:0];
								cnt_q      <= conv_len(first_in[2:0], ctrl_q[REJ_BIT]);
								conv_start <= 1'b1;
							end
						end
					end
					ST_CONV: begin
						// Count the conversion, then chain or close
						if (cnt_q <= CW'(1)) begin
							conv_done <= 1'b1;
							if (!next_in[3]) begin
								idx_q      <= next_in[2:0];
								cnt_q      <= conv_len(next_in[2:0], ctrl_q[REJ_BIT]);
								conv_start <= 1'b1;
							end else begin
								state_q <= ST_IDLE;
								// Continuous restarts, single ends the pass
								pass_q  <= (ctrl_q[SEQ_MSB:SEQ_LSB] == SEQ_CONT);
							end
						end else begin
							cnt_q <= cnt_q - CW'(1);
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Status outputs from flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			adc_busy    <= 1'b0;
			adc_powered <= 1'b1;
			conv_input  <= 3'h0;
		end else begin
			adc_busy    <= (state_q == ST_PWRUP) || (state_q == ST_CONV) || pass_q;
			adc_powered <= (state_q != ST_OFF);
			conv_input  <= idx_q;
		end
	end
endmodule : adcsq_top

// [sim/adcsq_asserts.sv]
`timescale 1ns/1ps
module adcsq_asserts #(
	parameter int CONV_COUNT = 4,
	parameter int DIAG_COUNT = 20
) (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic        adc_busy,
	input wire logic        adc_powered,
	input wire logic        conv_start,
	input wire logic        conv_done
);
	localparam int DG_MAX = DIAG_COUNT + 2; // Longest conversion plus margin
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic ctl_wr; // Write to either control alias
	assign ctl_wr = reg_wr && (reg_addr == adcsq_pkg::ADDR_CONV_CTRL ||
		reg_addr == adcsq_pkg::ADDR_CONV_CTRL_FAST);
	sequence s_go; ctl_wr && reg_wdata[9:8] == 2'h1 && reg_wdata[0] && adc_powered && !adc_busy; endsequence
	sequence s_dn; ctl_wr && reg_wdata[9:8] == 2'h3; endsequence
	property p_go; s_go |-> ##[2:3] conv_start; endproperty
	a_go: assert property (p_go) else $error("no pass start");
	property p_dn; s_dn |-> ##[1:3] (!adc_powered && !adc_busy); endproperty
	a_dn: assert property (p_dn) else $error("no power down");
	property p_up; $rose(adc_powered) |-> ##1 (adc_busy && !conv_start) [*8]; endproperty
	a_up: assert property (p_up) else $error("busy low in power up");
	property p_sb; conv_start |-> adc_busy && adc_powered; endproperty
	a_sb: assert property (p_sb) else $error("start while idle");
	property p_dp; conv_done |=> !conv_done; endproperty
	a_dp: assert property (p_dp) else $error("done not a pulse");
	property p_cb; conv_start |-> ##[1:DG_MAX] (conv_done || !adc_busy); endproperty
	a_cb: assert property (p_cb) else $error("conversion hangs");
	property p_cm; conv_start |=> !conv_done [*2]; endproperty
	a_cm: assert property (p_cm) else $error("conversion too short");
	property p_oq; !adc_powered |-> !conv_start && !conv_done; endproperty
	a_oq: assert property (p_oq) else $error("activity when off");
	property p_id; ctl_wr && reg_wdata[9:8] == 2'h0 |=> ##1 !conv_start [*3]; endproperty
	a_id: assert property (p_id) else $error("idle did not stop");
endmodule : adcsq_asserts
bind adcsq_top adcsq_asserts #(.CONV_COUNT(CONV_COUNT), .DIAG_COUNT(SLOW_COUNT)) u_adcsq_asserts (
	.ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .adc_busy, .adc_powered, .conv_start, .conv_done);

// [sim/adcsq_host.sv]
`timescale 1ns/1ps
// Host side: register writes, reads and busy polling
module adcsq_host (
	input  wire logic        ref_clk,
	input  wire logic        adc_busy,
	input  wire logic [15:0] reg_rdata,
	output logic      [7:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata
);
	initial begin
		{reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
	end
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge ref_clk);
		#1 reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		#1 {reg_addr, reg_rd} = {a, 1'b1};
		@(posedge ref_clk);
		#1 reg_rd = 1'b0;
		@(posedge ref_clk);
		#1 d = reg_rdata;
	endtask : rd
	// Never start a new pass before busy reads 0
	task wait_idle;
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 300 && adc_busy !== 1'b0; i++) @(posedge ref_clk);
		#1;
	endtask : wait_idle
endmodule : adcsq_host

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import adcsq_pkg::*;
	localparam int PW = 10, SL = 20, FA = 8;
	logic ref_clk = 0, rst = 1, reg_wr, reg_rd, adc_busy, adc_powered, conv_start, conv_done;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rv;
	logic [2:0] conv_input, seen[$];
	int n_fail = 0, compares = 0, n_done = 0, dur = 0, fd, n0;
	time t_st;
	adcsq_top #(.PWRUP_COUNT(PW), .SLOW_COUNT(SL), .FAST_COUNT(FA), .CONV_COUNT(4)) u_adcsq_top (
		.ref_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.adc_busy, .adc_powered, .conv_start, .conv_input, .conv_done);
	adcsq_host u_adcsq_host (.ref_clk, .adc_busy, .reg_rdata, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata);
	initial forever #10 ref_clk = ~ref_clk;
	// Log each finished conversion and its length
	always @(posedge ref_clk) begin
		if (conv_done) begin
			seen.push_back(conv_input);
			n_done++;
			dur = int'(($time - t_st) / 20);
		end
		if (conv_start) t_st = $time;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task final_report;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	// Watchdog: whole run needs about 180 cycles
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		#1 rst = 0;
		u_adcsq_host.rd(ADDR_CONV_CTRL, rv);
		chk(rv, CONV_CTRL_RESET);
		u_adcsq_host.rd(8'h40, rv);
		chk(rv, 16'h0000);
		u_adcsq_host.wr(ADDR_CONV_CTRL, 16'hF9A5);
		u_adcsq_host.wait_idle();
		chk(16'(adc_busy), 16'h0000);
		chk(16'(seen.size()), 16'h0004);
		chk({seen[0], seen[1], seen[2], seen[3], 4'h0}, 16'h0AF0);
		u_adcsq_host.rd(ADDR_CONV_CTRL, rv);
		chk(rv, 16'h01A5);
		fd = dur;
		$display("single pass done");
		u_adcsq_host.wr(ADDR_CONV_CTRL_FAST, 16'h0510);
		u_adcsq_host.wait_idle();
		chk(16'(adc_busy), 16'h0000);
		chk(16'(dur - fd), 16'(SL - FA));
		seen.delete();
		u_adcsq_host.wr(ADDR_CONV_CTRL, 16'h0203);
		repeat (60) @(posedge ref_clk);
		#1;
		chk({adc_busy, seen[0], seen[1], seen[2]}, 16'h0208);
		u_adcsq_host.wr(ADDR_CONV_CTRL, 16'h0003);
		repeat (3) @(posedge ref_clk);
		#1;
		chk(16'(adc_busy), 16'h0000);
		$display("continuous done");
		u_adcsq_host.wr(ADDR_CONV_CTRL, 16'h0300);
		repeat (3) @(posedge ref_clk);
		#1;
		chk(16'(adc_powered), 16'h0000);
		u_adcsq_host.wr(ADDR_CONV_CTRL, 16'h0101);
		n0 = n_done;
		repeat (PW) @(posedge ref_clk);
		#1;
		chk({adc_busy, 15'(n_done - n0)}, 16'h8000);
		u_adcsq_host.wait_idle();
		chk(16'(adc_busy), 16'h0000);
		chk({adc_powered, 15'(n_done - n0)}, 16'h8001);
		u_adcsq_host.wr(ADDR_CONV_CTRL, 16'h0300);
		u_adcsq_host.wr(ADDR_CONV_CTRL, 16'h0000);
		repeat (3) @(posedge ref_clk);
		#1;
		chk(16'(adc_busy), 16'h0001);
		u_adcsq_host.wait_idle();
		chk(16'(adc_busy), 16'h0000);
		chk(16'(adc_powered), 16'h0001);
		$display("power tests done");
		final_report();
	end
endmodule : testbench
